/* File: src/rwi_reset_ctrl.sv */
// Contract
// RULE_01: Reset is entered on power-on detection, an enabled dog timer time-out, or the reset pin driven low.
// RULE_02: Power-on detection is always active and no bit can disable it.
// RULE_03: The main oscillator is kept running, or started, during and after any reset.
// RULE_04: Any reset loads the program counter with zero.
// RULE_05: Any reset makes every port pin an input with its driver off.
// RULE_06: Any reset clears the tick counter, the dog timer and the shared prescaler.
// RULE_07: Power-on reset alone clears bits 5 and 6 of the status flags and the top two bits of the RAM select.
// RULE_08: Reset sets every tick counter control bit to one except bit 6, which is cleared.
// RULE_09: Power-on and pin or dog reset load the same values, except the RAM buffer which pin or dog reset keeps.
// RULE_10: A wake-up from a port change keeps every listed control register.
// RULE_11: An enabled dog time-out resets the device in normal, green or idle mode.
// RULE_12: A level change on port 6 or port 8 can wake the device instead of raising an interrupt.
// RULE_13: Internal reset is held while any source is active and released on the core clock once all are gone.
module rwi_reset_ctrl (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic supply_low,
  input wire logic ext_reset_n,
  input wire logic dog_timeout,
  input wire logic dog_enable,
  input wire rwi_pkg::rwi_mode_t core_mode,
  input wire logic [15:0] port_pins,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic core_reset,
  output logic osc_run,
  output logic [7:0] program_counter,
  output logic timers_clear,
  output logic por_flag_clear,
  output logic [7:0] status_flags_mask,
  output logic [7:0] ram_select_mask,
  output logic wake_pulse,
  output logic [7:0] port5_oe,
  output logic [7:0] port6_oe,
  output logic [7:0] port7_oe,
  output logic [7:0] port8_oe
);
  import rwi_pkg::*;

  // ==========================================================
  // Input synchronisation
  rwi_sync_if sy();
  rwi_sync #(.PORT_W(16)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .supply_low(supply_low),
    .ext_reset_n(ext_reset_n),
    .port_pins(port_pins),
    .sy(sy)
  );

  // ==========================================================
  // Source merge
  logic dog_hit;
  logic any_src;
  logic is_por;
  rwi_state_t state_r;
  rwi_src_t cause_r;
  logic por_seen_r;
  // Dog timeout arrives from logic on mclk, so no synchroniser
  assign dog_hit = dog_timeout && dog_enable && (core_mode != RWI_MODE_SLEEP); // [RULE_11]
  // Power-on path has no enable term at all
  assign is_por = sy.por_req; // [RULE_02]
  assign any_src = is_por || sy.pin_req || dog_hit; // [RULE_01]

  // ==========================================================
  // Wake detect on ports 6 and 8
  logic [15:0] port_prev_r;
  logic [7:0] wake_osc_r;
  logic wake_hit;
  logic p6_change;
  logic p8_change;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      port_prev_r <= '1;
    end else begin
      port_prev_r <= sy.port_in;
    end
  end
  assign p6_change = |(port_prev_r[7:0] ^ sy.port_in[7:0]);
  assign p8_change = |(port_prev_r[15:8] ^ sy.port_in[15:8]);
  // Wake enables are active low; only meaningful while sleeping
  assign wake_hit = (core_mode == RWI_MODE_SLEEP) && (state_r == RWI_RUN)
                    && ((p6_change && !wake_osc_r[WAKE_P6_BIT])
                    || (p8_change && !wake_osc_r[WAKE_P8_BIT])); // [RULE_12]

  // ==========================================================
  // Sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= RWI_HOLD;
    end else begin
      case (state_r)
        RWI_RUN: begin
          if (any_src) begin
            state_r <= RWI_HOLD;
          end else if (wake_hit) begin
            state_r <= RWI_WAKE;
          end
        end
        RWI_HOLD: begin
          if (!any_src) begin
            state_r <= RWI_RUN; // [RULE_13]
          end
        end
        RWI_WAKE: begin
          state_r <= any_src ? RWI_HOLD : RWI_RUN;
        end
        default: begin
          state_r <= RWI_HOLD;
        end
      endcase
    end
  end

  // Cause latch: power-on outranks pin, pin outranks dog
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cause_r <= RWI_SRC_POR;
      por_seen_r <= 1'b1;
    end else if (is_por) begin
      cause_r <= RWI_SRC_POR;
      por_seen_r <= 1'b1;
    end else if (sy.pin_req) begin
      cause_r <= RWI_SRC_PIN;
    end else if (dog_hit) begin
      cause_r <= RWI_SRC_DOG;
    end else if (state_r == RWI_RUN) begin
      por_seen_r <= 1'b0;
    end
  end

  logic in_reset;
  assign in_reset = (state_r == RWI_HOLD) || any_src;
  assign core_reset = in_reset; // [RULE_13]
  assign osc_run = 1'b1; // [RULE_03]
  assign timers_clear = in_reset; // [RULE_06]
  assign wake_pulse = (state_r == RWI_WAKE);
  // Core applies these masks as AND while por_flag_clear is high
  assign por_flag_clear = in_reset && (is_por || por_seen_r); // [RULE_07]
  assign status_flags_mask = STATUS_POR_CLR;
  assign ram_select_mask = RAMSEL_POR_CLR;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      program_counter <= PC_RESET;
    end else if (in_reset) begin
      program_counter <= PC_RESET; // [RULE_04]
    end
  end

  // ==========================================================
  // Control registers
  logic [7:0] p5_dir_r;
  logic [7:0] p6_dir_r;
  logic [7:0] p7_dir_r;
  logic [7:0] p8_dir_r;
  logic [7:0] ram_ptr_r;
  logic [7:0] ram_buf_r;
  logic [7:0] cnt1_pre_r;
  logic [7:0] cnt2_pre_r;
  logic [7:0] hpw_pre_r;
  logic [7:0] lpw_pre_r;
  logic [7:0] int_mask_r;
  logic [7:0] tick_ctrl_r;
  logic sw_ok;
  // Writes are refused while the core is held; wake leaves everything alone
  assign sw_ok = reg_wr && !in_reset; // [RULE_10]

  // One block per register keeps each reset path easy to trace
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      p5_dir_r <= RST_P5_DIR;
    end else if (in_reset) begin
      p5_dir_r <= RST_P5_DIR; // [RULE_05]
    end else if (sw_ok && reg_addr == ADDR_P5_DIR) begin
      p5_dir_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      p6_dir_r <= RST_DIR_ALL_IN;
    end else if (in_reset) begin
      p6_dir_r <= RST_DIR_ALL_IN; // [RULE_05]
    end else if (sw_ok && reg_addr == ADDR_P6_DIR) begin
      p6_dir_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      p7_dir_r <= RST_DIR_ALL_IN;
    end else if (in_reset) begin
      p7_dir_r <= RST_DIR_ALL_IN; // [RULE_05]
    end else if (sw_ok && reg_addr == ADDR_P7_DIR) begin
      p7_dir_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      p8_dir_r <= RST_DIR_ALL_IN;
    end else if (in_reset) begin
      p8_dir_r <= RST_DIR_ALL_IN; // [RULE_05]
    end else if (sw_ok && reg_addr == ADDR_P8_DIR) begin
      p8_dir_r <= reg_wdata;
    end
  end

  // Port 5 low nibble holds speed bits; its pins are the high nibble only
  assign port5_oe = {~p5_dir_r[7:4], 4'h0} & {8{!in_reset}}; // [RULE_05]
  assign port6_oe = ~p6_dir_r & {8{!in_reset}};
  assign port7_oe = ~p7_dir_r & {8{!in_reset}};
  assign port8_oe = ~p8_dir_r & {8{!in_reset}};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ram_ptr_r <= RST_ZERO;
    end else if (in_reset) begin
      ram_ptr_r <= RST_ZERO; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_RAM_PTR) begin
      ram_ptr_r <= reg_wdata & RAM_PTR_MASK;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt1_pre_r <= RST_ZERO;
    end else if (in_reset) begin
      cnt1_pre_r <= RST_ZERO; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_CNT1_PRE) begin
      cnt1_pre_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt2_pre_r <= RST_ZERO;
    end else if (in_reset) begin
      cnt2_pre_r <= RST_ZERO; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_CNT2_PRE) begin
      cnt2_pre_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hpw_pre_r <= RST_ZERO;
    end else if (in_reset) begin
      hpw_pre_r <= RST_ZERO; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_HPW_PRE) begin
      hpw_pre_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lpw_pre_r <= RST_ZERO;
    end else if (in_reset) begin
      lpw_pre_r <= RST_ZERO; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_LPW_PRE) begin
      lpw_pre_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_mask_r <= RST_ZERO;
    end else if (in_reset) begin
      int_mask_r <= RST_ZERO; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_INT_MASK) begin
      int_mask_r <= reg_wdata;
    end
  end

  // Unknown bits kept as they are; the enables come back on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_osc_r <= RST_ZERO;
    end else if (in_reset) begin
      wake_osc_r <= wake_osc_r & WAKE_OSC_KEEP; // [RULE_09]
    end else if (sw_ok && reg_addr == ADDR_WAKE_OSC) begin
      wake_osc_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_ctrl_r <= RST_TICK_CTRL;
    end else if (in_reset) begin
      tick_ctrl_r <= RST_TICK_CTRL; // [RULE_08]
    end else if (sw_ok && reg_addr == ADDR_TICK_CTRL) begin
      tick_ctrl_r <= reg_wdata;
    end
  end

  // RAM buffer: no reset clause, so pin and dog resets keep it
  always_ff @(posedge mclk) begin
    if (sw_ok && reg_addr == ADDR_RAM_BUF) begin
      ram_buf_r <= reg_wdata; // [RULE_09]
    end
  end

  // ==========================================================
  // Read port, data one cycle after the strobe
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = RST_ZERO;
    case (reg_addr)
      ADDR_P5_DIR: rd_nxt = p5_dir_r;
      ADDR_P6_DIR: rd_nxt = p6_dir_r;
      ADDR_P7_DIR: rd_nxt = p7_dir_r;
      ADDR_P8_DIR: rd_nxt = p8_dir_r;
      ADDR_RAM_PTR: rd_nxt = ram_ptr_r;
      ADDR_RAM_BUF: rd_nxt = ram_buf_r;
      ADDR_CNT1_PRE: rd_nxt = cnt1_pre_r;
      ADDR_CNT2_PRE: rd_nxt = cnt2_pre_r;
      ADDR_HPW_PRE: rd_nxt = hpw_pre_r;
      ADDR_LPW_PRE: rd_nxt = lpw_pre_r;
      ADDR_INT_MASK: rd_nxt = int_mask_r;
      ADDR_WAKE_OSC: rd_nxt = wake_osc_r;
      ADDR_TICK_CTRL: rd_nxt = tick_ctrl_r;
      ADDR_RST_CAUSE: rd_nxt = {5'h00, por_seen_r, cause_r};
      default: rd_nxt = RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= RST_ZERO;
    end
  end
endmodule : rwi_reset_ctrl

/* File: src/rwi_pkg.sv */
package rwi_pkg;
  // ==========================================================
  // Register offsets (index space of the plain register port)
  localparam logic [7:0] ADDR_P5_DIR = 8'h05;
  localparam logic [7:0] ADDR_P6_DIR = 8'h06;
  localparam logic [7:0] ADDR_P7_DIR = 8'h07;
  localparam logic [7:0] ADDR_P8_DIR = 8'h08;
  localparam logic [7:0] ADDR_RAM_PTR = 8'h09;
  localparam logic [7:0] ADDR_RAM_BUF = 8'h0a;
  localparam logic [7:0] ADDR_CNT1_PRE = 8'h0b;
  localparam logic [7:0] ADDR_CNT2_PRE = 8'h0c;
  localparam logic [7:0] ADDR_HPW_PRE = 8'h0d;
  localparam logic [7:0] ADDR_LPW_PRE = 8'h0e;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0f;
  localparam logic [7:0] ADDR_WAKE_OSC = 8'h16;
  localparam logic [7:0] ADDR_TICK_CTRL = 8'h17;
  localparam logic [7:0] ADDR_RST_CAUSE = 8'h20;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_P5_DIR = 8'hf0;
  localparam logic [7:0] RST_DIR_ALL_IN = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TICK_CTRL = 8'hbf;
  localparam logic [7:0] WAKE_OSC_KEEP = 8'h70;
  localparam logic [7:0] STATUS_POR_CLR = 8'h9f;
  localparam logic [7:0] RAMSEL_POR_CLR = 8'h3f;
  localparam logic [7:0] RAM_PTR_MASK = 8'h7f;
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam int WAKE_P6_BIT = 1;
  localparam int WAKE_P8_BIT = 3;
  localparam int TICK_INT_BIT = 6;
  // ==========================================================
  // Sequencer states, reset causes and core modes
  typedef enum logic [1:0] {
    RWI_RUN = 2'b00,
    RWI_HOLD = 2'b01,
    RWI_WAKE = 2'b10
  } rwi_state_t;
  typedef enum logic [1:0] {
    RWI_SRC_NONE = 2'b00,
    RWI_SRC_POR = 2'b01,
    RWI_SRC_PIN = 2'b10,
    RWI_SRC_DOG = 2'b11
  } rwi_src_t;
  typedef enum logic [1:0] {
    RWI_MODE_NORMAL = 2'b00,
    RWI_MODE_GREEN = 2'b01,
    RWI_MODE_IDLE = 2'b10,
    RWI_MODE_SLEEP = 2'b11
  } rwi_mode_t;
endpackage : rwi_pkg

/* File: src/rwi_sync_if.sv */
interface rwi_sync_if;
  logic por_req;
  logic pin_req;
  logic [15:0] port_in;
  modport src (output por_req, output pin_req, output port_in);
  modport dst (input por_req, input pin_req, input port_in);
endinterface : rwi_sync_if

/* File: src/rwi_sync.sv */
module rwi_sync #(
  parameter int PORT_W = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic supply_low,
  input wire logic ext_reset_n,
  input wire logic [PORT_W-1:0] port_pins,
  rwi_sync_if.src sy
);
  // ==========================================================
  // Two-stage synchronisers for every pin
  logic [PORT_W+1:0] s1_r;
  logic [PORT_W+1:0] s2_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= {supply_low, ~ext_reset_n, port_pins};
      s2_r <= s1_r;
    end
  end
  assign sy.por_req = s2_r[PORT_W+1];
  assign sy.pin_req = s2_r[PORT_W];
  assign sy.port_in = s2_r[PORT_W-1:0];
  // Bit map of the pin vector is fixed by the top, so refuse other widths
  if (PORT_W != 16) begin : g_bad_width
    $error("rwi_sync: PORT_W must be 16");
  end
endmodule : rwi_sync

/* File: verif/rwi_reset_ctrl_monitor.sv */
module rwi_reset_ctrl_monitor
  import rwi_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic supply_low,
  input wire logic ext_reset_n,
  input wire logic dog_timeout,
  input wire logic dog_enable,
  input wire rwi_pkg::rwi_mode_t core_mode,
  input wire logic core_reset,
  input wire logic osc_run,
  input wire logic [7:0] program_counter,
  input wire logic timers_clear,
  input wire logic por_flag_clear,
  input wire logic [7:0] status_flags_mask,
  input wire logic [7:0] ram_select_mask,
  input wire logic wake_pulse,
  input wire logic [7:0] port5_oe,
  input wire logic [7:0] port6_oe,
  input wire logic [7:0] port7_oe,
  input wire logic [7:0] port8_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_osc_kept_on: assert property (osc_run)
    else $error("oscillator stopped");
  a_pin_enters_reset: assert property (!ext_reset_n [*3] |-> core_reset)
    else $error("pin low without reset");
  a_por_enters_reset: assert property (supply_low [*3] |-> core_reset && por_flag_clear)
    else $error("low supply without power-on reset");
  a_dog_resets_core: assert property (dog_timeout && dog_enable && core_mode != RWI_MODE_SLEEP |-> ##[0:2] core_reset)
    else $error("dog time-out ignored");
  a_pc_zero_reset: assert property (core_reset |=> program_counter == PC_RESET)
    else $error("program counter not zero");
  a_oe_off_reset: assert property (core_reset |-> (port5_oe | port6_oe | port7_oe | port8_oe) == 8'h00)
    else $error("port driver on in reset");
  a_p5_low_off: assert property (port5_oe[3:0] == 4'h0)
    else $error("port5 low nibble driven");
  a_timers_follow: assert property (timers_clear == core_reset)
    else $error("timer clear not tied to reset");
  a_por_masks_fixed: assert property (status_flags_mask == STATUS_POR_CLR && ram_select_mask == RAMSEL_POR_CLR)
    else $error("power-on masks wrong");
  // Six quiet cycles covers sync depth plus hold state
  a_release_quiet: assert property ((ext_reset_n && !supply_low && !dog_timeout) [*6] |-> !core_reset)
    else $error("reset held with no source");
  a_wake_one_cycle: assert property (wake_pulse |-> !core_reset ##1 !wake_pulse)
    else $error("wake pulse wrong");
  c_release: cover property ($fell(core_reset));
  c_wake: cover property (wake_pulse);
  c_por: cover property (por_flag_clear && core_reset);
endmodule : rwi_reset_ctrl_monitor

/* File: verif/rwi_supply_pin_model.sv */
module rwi_supply_pin_model (
  input wire logic mclk,
  input wire logic por_on,
  input wire logic pin_on,
  output logic supply_low,
  output logic ext_reset_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Levels move only on the clock edge so no glitch reaches the syncs
  initial begin
    supply_low = 1'b0;
    ext_reset_n = 1'b1;
  end
  always @(posedge mclk) begin
    supply_low <= por_on;
    ext_reset_n <= ~pin_on;
  end
endmodule : rwi_supply_pin_model

/* File: verif/test_reset_and_wakeup_init.sv */
module test_reset_and_wakeup_init;
  timeunit 1ns;
  timeprecision 1ps;
  import rwi_pkg::*;
  logic mclk, rstn, dog_timeout, dog_enable, reg_wr, reg_rd, por_on, pin_on, supply_low, ext_reset_n, seen;
  rwi_mode_t core_mode;
  logic [15:0] port_pins;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, program_counter, status_flags_mask, ram_select_mask, v;
  logic [7:0] port5_oe, port6_oe, port7_oe, port8_oe;
  logic core_reset, osc_run, timers_clear, por_flag_clear, wake_pulse;
  int mismatches, num_checks;
  localparam logic [7:0] DA [13] = '{ADDR_P5_DIR, ADDR_P6_DIR, ADDR_P7_DIR, ADDR_P8_DIR, ADDR_RAM_PTR,
    ADDR_CNT1_PRE, ADDR_CNT2_PRE, ADDR_HPW_PRE, ADDR_LPW_PRE, ADDR_INT_MASK, ADDR_WAKE_OSC, ADDR_TICK_CTRL, 8'h30};
  localparam logic [7:0] DV [13] = '{8'hf0, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hbf, 8'h00};
  rwi_reset_ctrl rwi_reset_ctrl_i (.mclk(mclk), .rstn(rstn), .supply_low(supply_low), .ext_reset_n(ext_reset_n),
    .dog_timeout(dog_timeout), .dog_enable(dog_enable), .core_mode(core_mode), .port_pins(port_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_reset(core_reset), .osc_run(osc_run), .program_counter(program_counter), .timers_clear(timers_clear),
    .por_flag_clear(por_flag_clear), .status_flags_mask(status_flags_mask), .ram_select_mask(ram_select_mask),
    .wake_pulse(wake_pulse), .port5_oe(port5_oe), .port6_oe(port6_oe), .port7_oe(port7_oe), .port8_oe(port8_oe));
  rwi_supply_pin_model rwi_supply_pin_model_i (.mclk(mclk), .por_on(por_on), .pin_on(pin_on),
    .supply_low(supply_low), .ext_reset_n(ext_reset_n));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Writes are dropped while reset holds, so every reset scenario waits here
  task automatic run;
    for (int n = 0; n < 40 && core_reset !== 1'b0; n++) @(posedge mclk) #1;
    chk(8'(core_reset), 8'h00);
  endtask : run
  task automatic defaults;
    for (int i = 0; i < 13; i++) begin
      rd(DA[i], v);
      chk(v, DV[i]);
    end
  endtask : defaults
  task automatic hit(input logic por);
    @(posedge mclk);
    por_on <= por;
    pin_on <= !por;
    repeat (4) @(posedge mclk);
    #1 chk(8'(core_reset), 8'h01);
    chk(program_counter, PC_RESET);
    chk(8'(timers_clear), 8'h01);
    chk(8'(osc_run), 8'h01);
    chk(port6_oe, 8'h00);
    chk(8'(por_flag_clear), 8'(por));
    @(posedge mclk);
    por_on <= 1'b0;
    pin_on <= 1'b0;
    run();
    defaults();
    rd(ADDR_RST_CAUSE, v);
    chk(8'(v[1:0]), por ? 8'h01 : 8'h02);
  endtask : hit
  // ==========================================================
  // Scenarios
  task automatic t_pin;
    wr(ADDR_INT_MASK, 8'h55);
    wr(ADDR_P6_DIR, 8'h0f);
    wr(ADDR_RAM_BUF, 8'ha5);
    wr(ADDR_RAM_PTR, 8'hff);
    rd(ADDR_RAM_PTR, v);
    chk(v, RAM_PTR_MASK);
    #1 chk(port6_oe, 8'hf0);
    hit(1'b0);
    rd(ADDR_RAM_BUF, v);
    chk(v, 8'ha5);
    hit(1'b1);
    $display("test pin and power-on reset done");
  endtask : t_pin
  task automatic t_dog;
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      dog_enable <= (i < 4);
      core_mode <= rwi_mode_t'(i[1:0]);
      dog_timeout <= 1'b1;
      @(posedge mclk);
      dog_timeout <= 1'b0;
      #1 seen = core_reset;
      repeat (3) @(posedge mclk) #1 seen |= core_reset;
      chk(8'(seen), 8'(i < 3));
      run();
      rd(ADDR_RST_CAUSE, v);
      chk(v, 8'h03);
    end
    $display("test dog time-out done");
  endtask : t_dog
  task automatic t_wake;
    @(posedge mclk);
    core_mode <= RWI_MODE_SLEEP;
    wr(ADDR_INT_MASK, 8'h33);
    wr(ADDR_WAKE_OSC, 8'h00);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wr(ADDR_WAKE_OSC, 8'h0a);
      @(posedge mclk);
      port_pins <= port_pins ^ (k == 1 ? 16'h0100 : 16'h0001);
      seen = 1'b0;
      repeat (8) @(posedge mclk) #1 seen |= wake_pulse;
      chk(8'(seen), 8'(k < 2));
      rd(ADDR_INT_MASK, v);
      chk(v, 8'h33);
    end
    $display("test wake-up done");
  endtask : t_wake
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {rstn, dog_timeout, dog_enable, reg_wr, reg_rd, por_on, pin_on} = '0;
    core_mode = RWI_MODE_NORMAL;
    port_pins = 16'h0000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    run();
    defaults();
    $display("test reset values done");
    t_pin();
    t_dog();
    t_wake();
    report_and_stop();
  end
endmodule : test_reset_and_wakeup_init
bind rwi_reset_ctrl rwi_reset_ctrl_monitor rwi_reset_ctrl_monitor_i (.mclk(mclk), .rstn(rstn),
  .supply_low(supply_low), .ext_reset_n(ext_reset_n), .dog_timeout(dog_timeout), .dog_enable(dog_enable),
  .core_mode(core_mode), .core_reset(core_reset), .osc_run(osc_run), .program_counter(program_counter),
  .timers_clear(timers_clear), .por_flag_clear(por_flag_clear), .status_flags_mask(status_flags_mask),
  .ram_select_mask(ram_select_mask), .wake_pulse(wake_pulse), .port5_oe(port5_oe), .port6_oe(port6_oe),
  .port7_oe(port7_oe), .port8_oe(port8_oe));
